// [hw/nvmseq_pkg.sv]
/*
 * package for the nvm access sequencer: map, control bit layout, timing.
 * assumes a cpu-side data memory port with sector and offset from pointer.
 */
`default_nettype none
package nvmseq_pkg;
    localparam logic [7:0] PTR_LOW_CTRL   = 8'h40;  // control offset
    localparam logic [7:0] PTR_HIGH_CTRL  = 8'h01;  // sector holding it
    localparam logic [7:0] OFS_ADDR       = 8'h41;  // address register
    localparam logic [7:0] OFS_DATA       = 8'h42;  // data register
    localparam int         BIT_FETCH_GO   = 0;
    localparam int         BIT_FETCH_EN   = 1;
    localparam int         BIT_PROG_GO    = 2;
    localparam int         BIT_PROG_EN    = 3;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam int         CLK_MHZ        = 125;
    localparam int         READ_NS        = 40;
    localparam int         WRITE_US       = 4;
    localparam int         READ_CYC       = (READ_NS * CLK_MHZ + 999) / 1000;
    localparam int         WRITE_CYC      = WRITE_US * CLK_MHZ;

    typedef enum { NVMSEQ_IDLE, NVMSEQ_READ, NVMSEQ_WRITE } nvmseq_state_t;

    // one cpu data memory access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] sector;
        logic [7:0] offset;
        logic [7:0] wdata;
    } nvmseq_req_t;
endpackage
`default_nettype wire

// [hw/nvmseq_array.sv]
/*
 * byte-wide nonvolatile storage array.
 * assumes the sequencer holds addr and data stable through each cycle.
 */
`default_nettype none
module nvmseq_array #(
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [DEPTH];
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // storage has no reset, as a real array keeps its contents
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
    end

    always_comb
    begin
        rdata_next = mem[addr];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    assign rdata = rdata_reg;
endmodule
`default_nettype wire

// [hw/nvmseq_top.sv]
/*
 * nvm access sequencer: control register, address and data registers,
 * read and write cycle timing, done flag.
 * assumes cpu data memory requests arrive one per cycle on the clock, with
 * sector taken from the pointer high byte and offset from pointer low byte.
 */
// Overview of operation
// - control register reachable only when sector is one, not zero
// - control register sits at low byte 040H, high byte 01H
// - fetch enable is bit 1, fetch start bit 0
// - program enable is bit 3, program start bit 2
// - fetch start reads one during a read, zero when data ready
// - program start reads one during a write, zero when finished
// - fetch start ignored without fetch enable; hardware clears it
// - program start ignored without program enable; hardware clears it
// - end of write sets the done flag, cleared when serviced
// - program enable is clear after reset
`default_nettype none
module nvmseq_top #(
    parameter int DEPTH     = 64,
    parameter int AW        = 6,
    parameter int WRITE_CYC = nvmseq_pkg::WRITE_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire nvmseq_pkg::nvmseq_req_t req,
    input  wire logic                    done_ack,
    output logic [7:0]                   rdata,
    output logic                         done_flag,
    output logic                         busy
);
    // the counter also times reads, so it must hold the longer of the two
    localparam int CNT_MAX = (WRITE_CYC > nvmseq_pkg::READ_CYC + 1)
                             ? WRITE_CYC : nvmseq_pkg::READ_CYC + 1;
    localparam int CW = $clog2(CNT_MAX + 1);

    nvmseq_pkg::nvmseq_state_t state_reg;
    nvmseq_pkg::nvmseq_state_t state_next;
    logic [7:0]    ctrl_reg;
    logic [7:0]    ctrl_next;
    logic [AW-1:0] addr_reg;
    logic [AW-1:0] addr_next;
    logic [7:0]    data_reg;
    logic [7:0]    data_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          done_reg;
    logic          done_next;
    logic [7:0]    rdata_reg;
    logic [7:0]    rdata_next;
    logic          busy_reg;
    logic          busy_next;
    logic          arr_we;
    logic [7:0]    arr_q;

    // decode an access to one of the three registers of sector one
    function automatic logic hit(input nvmseq_pkg::nvmseq_req_t r,
                                 input logic [7:0] ofs);
        hit = (r.sector == nvmseq_pkg::PTR_HIGH_CTRL)
              && (r.offset == ofs);
    endfunction

    nvmseq_array #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_array (
        .clk   (clk),
        .rst_n (rst_n),
        .we    (arr_we),
        .addr  (addr_reg),
        .wdata (data_reg),
        .rdata (arr_q)
    );

    assign arr_we = (state_reg == nvmseq_pkg::NVMSEQ_WRITE)
                    && (cnt_reg == CW'(1));

    // control, address and data registers plus the cycle sequencer
    always_comb
    begin
        logic [7:0] w;
        w          = req.wdata;
        state_next = state_reg;
        ctrl_next  = ctrl_reg;
        addr_next  = addr_reg;
        data_next  = data_reg;
        cnt_next   = cnt_reg;
        done_next  = done_reg;
        case (state_reg)
            nvmseq_pkg::NVMSEQ_IDLE:
            begin
                if (req.wr && hit(req, nvmseq_pkg::OFS_ADDR))
                    addr_next = w[AW-1:0];
                if (req.wr && hit(req, nvmseq_pkg::OFS_DATA))
                    data_next = w;
                if (req.wr && hit(req, nvmseq_pkg::PTR_LOW_CTRL))
                begin
                    ctrl_next = {4'h0, w[3:0]};
                    // start bits only take with their enable already set
                    ctrl_next[nvmseq_pkg::BIT_FETCH_GO] =
                        w[nvmseq_pkg::BIT_FETCH_GO]
                        && ctrl_reg[nvmseq_pkg::BIT_FETCH_EN];
                    ctrl_next[nvmseq_pkg::BIT_PROG_GO] =
                        w[nvmseq_pkg::BIT_PROG_GO]
                        && ctrl_reg[nvmseq_pkg::BIT_PROG_EN];
                    if (ctrl_next[nvmseq_pkg::BIT_PROG_GO])
                    begin
                        ctrl_next[nvmseq_pkg::BIT_FETCH_GO] = 1'b0;
                        state_next = nvmseq_pkg::NVMSEQ_WRITE;
                        cnt_next   = CW'(WRITE_CYC);
                    end
                    else if (ctrl_next[nvmseq_pkg::BIT_FETCH_GO])
                    begin
                        state_next = nvmseq_pkg::NVMSEQ_READ;
                        cnt_next   = CW'(nvmseq_pkg::READ_CYC + 1);
                    end
                end
            end
            nvmseq_pkg::NVMSEQ_READ, nvmseq_pkg::NVMSEQ_WRITE:
            begin
                // enables may change, start bits and addr/data are held
                if (req.wr && hit(req, nvmseq_pkg::PTR_LOW_CTRL))
                begin
                    ctrl_next[nvmseq_pkg::BIT_FETCH_EN] =
                        w[nvmseq_pkg::BIT_FETCH_EN];
                    ctrl_next[nvmseq_pkg::BIT_PROG_EN] =
                        w[nvmseq_pkg::BIT_PROG_EN];
                end
                cnt_next = cnt_reg - CW'(1);
                if (cnt_reg == CW'(1))
                begin
                    state_next = nvmseq_pkg::NVMSEQ_IDLE;
                    ctrl_next[nvmseq_pkg::BIT_FETCH_GO] = 1'b0;
                    ctrl_next[nvmseq_pkg::BIT_PROG_GO]  = 1'b0;
                    if (state_reg == nvmseq_pkg::NVMSEQ_WRITE)
                        done_next = 1'b1;
                    else
                        data_next = arr_q;
                end
            end
            default:
            begin
                state_next = nvmseq_pkg::NVMSEQ_IDLE;
            end
        endcase
        // set wins over a service clear in the same cycle
        if (done_ack && !(arr_we))
            done_next = 1'b0;
    end

    // read data mux: unmapped offsets or sector zero read as zero
    always_comb
    begin
        rdata_next = rdata_reg;
        busy_next  = (state_next != nvmseq_pkg::NVMSEQ_IDLE);
        if (req.rd)
        begin
            rdata_next = 8'h00;
            if (hit(req, nvmseq_pkg::PTR_LOW_CTRL))
                rdata_next = ctrl_next;
            else if (hit(req, nvmseq_pkg::OFS_ADDR))
                rdata_next = 8'(addr_reg);
            else if (hit(req, nvmseq_pkg::OFS_DATA))
                rdata_next = data_reg;
        end
    end

    // only registering; reset clears program enable and all control
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= nvmseq_pkg::NVMSEQ_IDLE;
            ctrl_reg  <= nvmseq_pkg::CTRL_RESET;
            addr_reg  <= '0;
            data_reg  <= 8'h00;
            cnt_reg   <= '0;
            done_reg  <= 1'b0;
            rdata_reg <= 8'h00;
            busy_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            ctrl_reg  <= ctrl_next;
            addr_reg  <= addr_next;
            data_reg  <= data_next;
            cnt_reg   <= cnt_next;
            done_reg  <= done_next;
            rdata_reg <= rdata_next;
            busy_reg  <= busy_next;
        end
    end

    assign rdata     = rdata_reg;
    assign done_flag = done_reg;
    assign busy      = busy_reg;

    a_sector_zero_blind: assert property (@(posedge clk) disable iff (!rst_n)
        req.wr && req.sector == 8'h00 && state_reg == nvmseq_pkg::NVMSEQ_IDLE
        |=> state_reg == nvmseq_pkg::NVMSEQ_IDLE)
        else $error("access through sector zero started a cycle");
    a_fetch_needs_en: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state_reg == nvmseq_pkg::NVMSEQ_READ)
        |-> $past(ctrl_reg[nvmseq_pkg::BIT_FETCH_EN]))
        else $error("read started without fetch enable");
    a_prog_needs_en: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state_reg == nvmseq_pkg::NVMSEQ_WRITE)
        |-> $past(ctrl_reg[nvmseq_pkg::BIT_PROG_EN]))
        else $error("write started without program enable");
    a_read_go_busy: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == nvmseq_pkg::NVMSEQ_READ
        |-> ctrl_reg[nvmseq_pkg::BIT_FETCH_GO])
        else $error("fetch start low during read");
    a_read_ends: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state_reg == nvmseq_pkg::NVMSEQ_READ)
        |-> ##[1:8] !ctrl_reg[nvmseq_pkg::BIT_FETCH_GO])
        else $error("read did not finish in time");
    a_write_go_busy: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == nvmseq_pkg::NVMSEQ_WRITE
        |-> ctrl_reg[nvmseq_pkg::BIT_PROG_GO] && busy_reg)
        else $error("program start or busy low during write");
    a_done_on_end: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == nvmseq_pkg::NVMSEQ_WRITE && cnt_reg == CW'(1)
        |=> done_reg && !ctrl_reg[nvmseq_pkg::BIT_PROG_GO])
        else $error("write end did not raise done flag");
    a_hold_addr: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg != nvmseq_pkg::NVMSEQ_IDLE
        && state_next != nvmseq_pkg::NVMSEQ_IDLE
        |=> $stable(addr_reg))
        else $error("address changed during a cycle");
    a_no_spurious_we: assert property (@(posedge clk) disable iff (!rst_n)
        arr_we |-> ctrl_reg[nvmseq_pkg::BIT_PROG_GO])
        else $error("array written without program start");
    c_read: cover property (@(posedge clk) disable iff (!rst_n)
        $fell(state_reg == nvmseq_pkg::NVMSEQ_READ));
    c_write: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(done_reg));
    c_busy_start: cover property (@(posedge clk) disable iff (!rst_n)
        busy_reg && req.wr && hit(req, nvmseq_pkg::PTR_LOW_CTRL));
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
/*
 * self-checking bench for the nvm access sequencer: register accesses
 * through sector 1, read and write cycles polled on their start bits.
 * assumes the design's own assertions and a short write time (16 cycles).
 */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int         WR_CYC = 16;
    localparam logic [7:0] SEC1   = nvmseq_pkg::PTR_HIGH_CTRL;
    localparam logic [7:0] CTRL   = nvmseq_pkg::PTR_LOW_CTRL;
    localparam logic [7:0] ADDR   = nvmseq_pkg::OFS_ADDR;
    localparam logic [7:0] DATA   = nvmseq_pkg::OFS_DATA;

    logic                   clk;
    logic                   rst_n;
    logic                   done_ack;
    logic                   done_flag;
    logic                   busy;
    logic [7:0]             rdata;
    logic [7:0]             v;
    nvmseq_pkg::nvmseq_req_t req;
    int                     err_count;
    int                     num_checks;
    int                     n;
    int                     cyc = 0;
    logic [7:0]             tst_addr [2] = '{8'h05, 8'h3f};
    logic [7:0]             tst_data [2] = '{8'ha5, 8'h5a};

    nvmseq_top #(
        .DEPTH     (64),
        .AW        (6),
        .WRITE_CYC (WR_CYC)
    ) dut (
        .clk       (clk),
        .rst_n     (rst_n),
        .req       (req),
        .done_ack  (done_ack),
        .rdata     (rdata),
        .done_flag (done_flag),
        .busy      (busy)
    );

    // free running clock, 8 ns period
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // cycle count, used to time a write from its start to the cleared bit
    always @(posedge clk)
        cyc <= cyc + 1;

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one access, then an idle cycle so no strobe is reassigned at once
    task automatic acc(input logic w, input logic [7:0] sec,
                       input logic [7:0] ofs, input logic [7:0] dat,
                       output logic [7:0] q);
        req = '{wr: w, rd: ~w, sector: sec, offset: ofs, wdata: dat};
        @(negedge clk);
        q = rdata;
        req = '0;
        @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
        logic [7:0] q;
        acc(1'b1, SEC1, ofs, dat, q);
    endtask

    task automatic rd(input logic [7:0] ofs, output logic [7:0] q);
        acc(1'b0, SEC1, ofs, 8'h00, q);
    endtask

    // poll one start bit until it clears; bounded so a stuck bit ends the run
    task automatic poll(input int b, output int cnt);
        logic [7:0] q;
        cnt = 0;
        do
        begin
            rd(CTRL, q);
            cnt++;
            if (cnt > 60)
            begin
                err_count++;
                $display("[ERR] start bit %0d never cleared", b);
                conclude();
            end
        end while (q[b] !== 1'b0);
    endtask

    task automatic wbyte(input logic [7:0] a, input logic [7:0] d);
        int t0;
        wr(ADDR, a);
        wr(DATA, d);
        wr(CTRL, 8'h08);
        wr(CTRL, 8'h0c);
        t0 = cyc;
        rd(CTRL, v);
        check("ctrl during write", v, 8'h0c);
        check("busy during write", {7'h00, busy}, 8'h01);
        // these land while busy and must not disturb the cycle
        wr(ADDR, ~a);
        wr(DATA, ~d);
        poll(nvmseq_pkg::BIT_PROG_GO, n);
        // polls land every second cycle, so the clear is seen a cycle late
        n = cyc - t0;
        v = {7'h00, n >= WR_CYC - 1 && n <= WR_CYC};
        check("write not instant", v, 8'h01);
        check("done flag set", {7'h00, done_flag}, 8'h01);
        done_ack = 1'b1;
        @(negedge clk);
        done_ack = 1'b0;
        @(negedge clk);
        check("done flag cleared", {7'h00, done_flag}, 8'h00);
        // writes made while busy must have been dropped
        rd(ADDR, v);
        check("address held while busy", v, a);
        rd(DATA, v);
        check("data held while busy", v, d);
        wr(CTRL, 8'h00);
    endtask

    task automatic rbyte(input logic [7:0] a, input logic [7:0] d);
        wr(CTRL, 8'h02);
        wr(ADDR, a);
        wr(CTRL, 8'h03);
        rd(CTRL, v);
        check("ctrl during read", v, 8'h03);
        poll(nvmseq_pkg::BIT_FETCH_GO, n);
        rd(DATA, v);
        check("read data", v, d);
        wr(CTRL, 8'h00);
    endtask

    // main sequence
    initial
    begin
        rst_n = 1'b0;
        req = '0;
        done_ack = 1'b0;
        err_count = 0;
        num_checks = 0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check("busy after reset", {7'h00, busy}, 8'h00);
        rd(CTRL, v);
        check("ctrl after reset", v, nvmseq_pkg::CTRL_RESET);
        // sector 0 must not reach the control register; a nonzero value
        // in it makes a leak through sector 0 visible
        wr(CTRL, 8'h02);
        acc(1'b1, 8'h00, CTRL, 8'h0a, v);
        acc(1'b0, 8'h00, CTRL, 8'h00, v);
        check("sector 0 read", v, 8'h00);
        rd(CTRL, v);
        check("ctrl after sector 0 write", v, 8'h02);
        rd(8'h43, v);
        check("unmapped offset", v, 8'h00);
        wr(CTRL, 8'h00);
        // start bits without their enables stay clear
        wr(CTRL, 8'h01);
        rd(CTRL, v);
        check("fetch start alone", v, 8'h00);
        // enable in the same write as start is not yet set, so no read
        wr(CTRL, 8'h03);
        rd(CTRL, v);
        check("fetch start with new enable", v, 8'h02);
        wr(CTRL, 8'h04);
        rd(CTRL, v);
        check("program start alone", v, 8'h00);
        check("no cycle started", {7'h00, busy}, 8'h00);
        // low address then top address, each read re-addressed
        for (int i = 0; i < 2; i++)
            wbyte(tst_addr[i], tst_data[i]);
        for (int i = 0; i < 2; i++)
            rbyte(tst_addr[i], tst_data[i]);
        conclude();
    end
endmodule
`default_nettype wire
